// file: ppom_pkg.sv
// shared constants for the port pin override multiplexer
package ppom_pkg;

    // pins in one port
    localparam int NPINS = 8;

    // register byte offsets on the avalon slave
    localparam logic [7:0] ADDR_DIR   = 8'h00; // pin direction bits
    localparam logic [7:0] ADDR_LATCH = 8'h04; // output latch bits
    localparam logic [7:0] ADDR_INPUT = 8'h08; // synced pin inputs
    localparam logic [7:0] ADDR_CTRL  = 8'h0C; // shared control bits
    localparam logic [7:0] ADDR_PCEN  = 8'h10; // pin change enables

    // control register field positions
    localparam int CTRL_PUD_BIT   = 0; // global pull-up disable
    localparam int CTRL_SLEEP_BIT = 1; // sleep clamp of inputs
    localparam int CTRL_AS2_BIT   = 2; // async timer clock select
    localparam int CTRL_EXTERNAL_CLOCK_SELECT_BIT = 3; // external clock select
    localparam int CTRL_INTRC_BIT = 4; // chip clock is internal rc
    localparam int CTRL_EXTCK_BIT = 5; // chip clock is external clock
    localparam int CTRL_WIDTH     = 6;

    // reset values
    localparam logic [7:0] DIR_RESET   = 8'h00; // all inputs
    localparam logic [7:0] LATCH_RESET = 8'h00; // no pull-ups
    localparam logic [7:0] PCEN_RESET  = 8'h00;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h10;

    // oscillator pins of the port
    localparam int OSC_IN_PIN  = 6;
    localparam int OSC_OUT_PIN = 7;

    // read answer of an unmapped offset
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

endpackage

// file: ppom_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for the pin inputs
module ppom_sync (
    input  wire logic                      mclk_i,
    input  wire logic                      nrst_i,
    input  wire logic [ppom_pkg::NPINS-1:0] async_i,
    output logic      [ppom_pkg::NPINS-1:0] sync_o
);
    import ppom_pkg::*;

    logic [NPINS-1:0] meta_q;  // first stage, read only by stage two
    logic [NPINS-1:0] meta_d;
    logic [NPINS-1:0] sync_q;  // second stage
    logic [NPINS-1:0] sync_d;

    // next values: a plain shift through two stages
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // registers only
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule // ppom_sync

// file: ppom_pin.sv
`timescale 1ns/1ps
// override mux of one pin, purely combinational
module ppom_pin (
    input  wire logic dir_i,     // pin direction bit
    input  wire logic latch_i,   // pin output latch bit
    input  wire logic pud_i,     // global pull-up disable
    input  wire logic sleep_i,   // sleep clamp request
    input  wire logic pu_oe_i,   // pull-up override enable
    input  wire logic pu_ov_i,   // pull-up override value
    input  wire logic dd_oe_i,   // direction override enable
    input  wire logic dd_ov_i,   // direction override value
    input  wire logic pv_oe_i,   // port value override enable
    input  wire logic pv_ov_i,   // port value override value
    input  wire logic ie_oe_i,   // input enable override enable
    input  wire logic ie_ov_i,   // input enable override value
    output logic      pullup_o,  // pull-up enable to the pad
    output logic      oe_o,      // output driver enable
    output logic      out_o,     // driven level
    output logic      ie_o       // digital input enable
);
    // no flops here: an override reaches the pad in the same cycle
    always_comb begin
        // pull-up: override wins over direction, latch and disable
        if (pu_oe_i) begin
            pullup_o = pu_ov_i;
        end else begin
            pullup_o = ({dir_i, latch_i, pud_i} == 3'b010);
        end
        // driver enable
        oe_o = dd_oe_i ? dd_ov_i : dir_i;
        // value matters only while driving; low otherwise
        out_o = oe_o & (pv_oe_i ? pv_ov_i : latch_i);
        // input enable follows the sleep state unless overridden
        ie_o = ie_oe_i ? ie_ov_i : ~sleep_i;
    end

endmodule // ppom_pin

// file: ppom_top.sv
`timescale 1ns/1ps
// Summary of operation
// - pull-up override enable selects override value
// - else pull-up when dir,latch,disable = 010
// - driver follows direction override or direction bit
// - driven level is override value or latch
// - input enable follows override, pin change enable or sleep state
// - modules get unsynced schmitt output, sync themselves
// - analogue path straight from pad, no logic
// - strobes per port, clock/sleep/disable shared
// - async timer without external clock claims bit 7
// - async timer select claims bit 6
// - claimed oscillator pins never act as general I/O
// - timer oscillator only with rc clock, timer on
// - bit 6 is chip oscillator unless rc clock
// - every bit n is pin change source n
// - port offers spi, timer, clock-out functions
// - claimed bit 6 reads zero in direction, latch and input registers
module ppom_top (
    input  wire logic                      mclk_i,
    input  wire logic                      nrst_i,
    // avalon-mm slave
    input  wire logic [7:0]                avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic      [31:0]               avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // overrides from the peripheral modules, one bit per pin
    input  wire logic [ppom_pkg::NPINS-1:0] pullup_override_enable_i,
    input  wire logic [ppom_pkg::NPINS-1:0] pullup_override_value_i,
    input  wire logic [ppom_pkg::NPINS-1:0] direction_override_enable_i,
    input  wire logic [ppom_pkg::NPINS-1:0] direction_override_value_i,
    input  wire logic [ppom_pkg::NPINS-1:0] port_value_override_enable_i,
    input  wire logic [ppom_pkg::NPINS-1:0] port_value_override_value_i,
    input  wire logic [ppom_pkg::NPINS-1:0] input_enable_override_enable_i,
    input  wire logic [ppom_pkg::NPINS-1:0] input_enable_override_value_i,
    // pad side
    input  wire logic [ppom_pkg::NPINS-1:0] pad_in_i,
    output logic      [ppom_pkg::NPINS-1:0] pad_out_o,
    output logic      [ppom_pkg::NPINS-1:0] pad_oe_o,
    output logic      [ppom_pkg::NPINS-1:0] pad_pullup_en_o,
    output logic      [ppom_pkg::NPINS-1:0] pad_input_en_o,
    // towards the modules
    output logic      [ppom_pkg::NPINS-1:0] alt_function_raw_input_o,
    output logic      [ppom_pkg::NPINS-1:0] analogue_pad_path_o,
    output logic      [ppom_pkg::NPINS-1:0] pin_change_source_o,
    output logic                           chip_osc_claim_o,
    output logic                           timer_osc_claim_o
);
    import ppom_pkg::*;

    // offset match, used by both write and read decode
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // register state
    logic [NPINS-1:0]      dir_q;     // pin direction bits
    logic [NPINS-1:0]      dir_d;
    logic [NPINS-1:0]      latch_q;   // pin output latch bits
    logic [NPINS-1:0]      latch_d;
    logic [NPINS-1:0]      pcen_q;    // pin change enables
    logic [NPINS-1:0]      pcen_d;
    logic [CTRL_WIDTH-1:0] ctrl_q;    // shared control bits
    logic [CTRL_WIDTH-1:0] ctrl_d;
    logic                  rd_pend_q; // read data already loaded
    logic                  rd_pend_d;
    logic [31:0]           rdata_q;   // registered read data
    logic [31:0]           rdata_d;

    // write strobe, shared by all pins of the port
    logic                  wr_stb;
    logic [NPINS-1:0]      wdata;

    // decoded control fields
    logic                  global_pullup_disable;
    logic                  sleep;
    logic                  as2;
    logic                  external_clock_select;
    logic                  intrc;
    logic                  extck;

    // oscillator claims
    logic                  tosc_active;
    logic                  claim6;
    logic                  claim7;
    logic [NPINS-1:0]      clk_claim;

    // effective overrides after the oscillator takeover
    logic [NPINS-1:0]      pu_oe_eff;
    logic [NPINS-1:0]      pu_ov_eff;
    logic [NPINS-1:0]      dd_oe_eff;
    logic [NPINS-1:0]      dd_ov_eff;
    logic [NPINS-1:0]      pv_oe_eff;
    logic [NPINS-1:0]      pv_ov_eff;
    logic [NPINS-1:0]      ie_oe_eff;
    logic [NPINS-1:0]      ie_ov_eff;

    // input path
    logic [NPINS-1:0]      schmitt;   // clamped pad level
    logic [NPINS-1:0]      pin_sync;  // after the port synchroniser

    // control fields, common to every pin
    assign global_pullup_disable   = ctrl_q[CTRL_PUD_BIT];
    assign sleep = ctrl_q[CTRL_SLEEP_BIT];
    assign as2   = ctrl_q[CTRL_AS2_BIT];
    assign external_clock_select = ctrl_q[CTRL_EXTERNAL_CLOCK_SELECT_BIT];
    assign intrc = ctrl_q[CTRL_INTRC_BIT];
    assign extck = ctrl_q[CTRL_EXTCK_BIT];

    // timer oscillator needs the rc chip clock and the async timer
    assign tosc_active = intrc & as2;
    // bit 6: chip oscillator input for any non-rc clock, else tosc
    assign claim6 = ~intrc | tosc_active;
    // bit 7: crystal output, or the async timer without external clock;
    // detached even off the rc clock so it never acts as general I/O
    assign claim7 = (~intrc & ~extck) | (as2 & ~external_clock_select);
    assign chip_osc_claim_o  = ~intrc;
    assign timer_osc_claim_o = tosc_active;

    // claim vector, only the two oscillator pins can be taken
    always_comb begin
        clk_claim              = '0;
        clk_claim[OSC_IN_PIN]  = claim6;
        clk_claim[OSC_OUT_PIN] = claim7;
    end

    // a claimed pin is forced off: no pull-up, driver or input
    always_comb begin
        pu_oe_eff = pullup_override_enable_i | clk_claim;
        pu_ov_eff = pullup_override_value_i & ~clk_claim;
        dd_oe_eff = direction_override_enable_i | clk_claim;
        dd_ov_eff = direction_override_value_i & ~clk_claim;
        pv_oe_eff = port_value_override_enable_i & ~clk_claim;
        pv_ov_eff = port_value_override_value_i & ~clk_claim;
        // an enabled pin change source keeps its input alive in sleep
        ie_oe_eff = input_enable_override_enable_i | pcen_q | clk_claim;
        ie_ov_eff = ~clk_claim &
                    (~input_enable_override_enable_i |
                     input_enable_override_value_i);
    end

    // one mux per pin; spi, timer compare, capture and clock-out
    // functions of each bit arrive on the per-pin override lines
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            ppom_pin u_pin (
                .dir_i    (dir_q[gi]),
                .latch_i  (latch_q[gi]),
                .pud_i    (global_pullup_disable),
                .sleep_i  (sleep),
                .pu_oe_i  (pu_oe_eff[gi]),
                .pu_ov_i  (pu_ov_eff[gi]),
                .dd_oe_i  (dd_oe_eff[gi]),
                .dd_ov_i  (dd_ov_eff[gi]),
                .pv_oe_i  (pv_oe_eff[gi]),
                .pv_ov_i  (pv_ov_eff[gi]),
                .ie_oe_i  (ie_oe_eff[gi]),
                .ie_ov_i  (ie_ov_eff[gi]),
                .pullup_o (pad_pullup_en_o[gi]),
                .oe_o     (pad_oe_o[gi]),
                .out_o    (pad_out_o[gi]),
                .ie_o     (pad_input_en_o[gi])
            );
        end
    endgenerate

    // input clamp; modules see it before any synchroniser, so a
    // module not using it as a clock must sync it itself
    assign schmitt = pad_in_i & pad_input_en_o;
    assign alt_function_raw_input_o = schmitt;
    // analogue path bypasses clamp, mux and synchroniser
    assign analogue_pad_path_o = pad_in_i;

    // port synchroniser feeding the input register
    ppom_sync u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (schmitt),
        .sync_o  (pin_sync)
    );

    // each bit n is pin change source n when enabled
    assign pin_change_source_o = pin_sync & pcen_q;

    // only byte lane 0 carries data; other lanes are ignored
    assign wr_stb = avs_write_i & avs_byteenable_i[0];
    assign wdata  = avs_writedata_i[NPINS-1:0];

    // register next values and read data
    always_comb begin
        dir_d     = dir_q;
        latch_d   = latch_q;
        pcen_d    = pcen_q;
        ctrl_d    = ctrl_q;
        rd_pend_d = rd_pend_q;
        rdata_d   = rdata_q;
        if (wr_stb) begin
            if (hit(avs_address_i, ADDR_DIR)) begin
                dir_d = wdata;
            end
            if (hit(avs_address_i, ADDR_LATCH)) begin
                latch_d = wdata;
            end
            // writing ones to the input offset toggles the latch
            if (hit(avs_address_i, ADDR_INPUT)) begin
                latch_d = latch_q ^ wdata;
            end
            if (hit(avs_address_i, ADDR_CTRL)) begin
                ctrl_d = wdata[CTRL_WIDTH-1:0];
            end
            if (hit(avs_address_i, ADDR_PCEN)) begin
                pcen_d = wdata;
            end
        end
        // a read waits one cycle so read data come from a flop
        if (avs_read_i && !rd_pend_q) begin
            rd_pend_d = 1'b1;
            rdata_d   = RDATA_NONE;
            // claimed oscillator pins read as zero in direction, latch and input
            if (hit(avs_address_i, ADDR_DIR)) begin
                rdata_d[NPINS-1:0] = dir_q & ~clk_claim;
            end else if (hit(avs_address_i, ADDR_LATCH)) begin
                rdata_d[NPINS-1:0] = latch_q & ~clk_claim;
            end else if (hit(avs_address_i, ADDR_INPUT)) begin
                rdata_d[NPINS-1:0] = pin_sync & ~clk_claim;
            end else if (hit(avs_address_i, ADDR_CTRL)) begin
                rdata_d[CTRL_WIDTH-1:0] = ctrl_q;
            end else if (hit(avs_address_i, ADDR_PCEN)) begin
                rdata_d[NPINS-1:0] = pcen_q;
            end else begin
                rdata_d = RDATA_NONE;
            end
        end else if (avs_read_i) begin
            rd_pend_d = 1'b0;
        end else begin
            rd_pend_d = 1'b0;
        end
    end

    // registers only
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dir_q     <= DIR_RESET;
            latch_q   <= LATCH_RESET;
            pcen_q    <= PCEN_RESET;
            ctrl_q    <= CTRL_RESET;
            rd_pend_q <= 1'b0;
            rdata_q   <= RDATA_NONE;
        end else begin
            dir_q     <= dir_d;
            latch_q   <= latch_d;
            pcen_q    <= pcen_d;
            ctrl_q    <= ctrl_d;
            rd_pend_q <= rd_pend_d;
            rdata_q   <= rdata_d;
        end
    end

    // writes never wait; reads wait for their first cycle
    assign avs_waitrequest_o = avs_read_i & ~rd_pend_q;
    assign avs_readdata_o    = rdata_q;

    // checks on the mux and the register slave
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    property p_pu_override;
        (((pad_pullup_en_o ^ pullup_override_value_i) &
          pullup_override_enable_i & ~clk_claim) == '0);
    endproperty
    a_pu_override: assert property (p_pu_override)
        else $error("pull-up does not follow override value");

    property p_pu_normal;
        (((pad_pullup_en_o ^ (~dir_q & latch_q & {NPINS{~global_pullup_disable}})) &
          ~pu_oe_eff) == '0);
    endproperty
    a_pu_normal: assert property (p_pu_normal)
        else $error("pull-up wrong without override");

    property p_driver;
        ((pad_oe_o ^ (dd_oe_eff & dd_ov_eff | ~dd_oe_eff & dir_q)) == '0);
    endproperty
    a_driver: assert property (p_driver)
        else $error("driver enable wrong");

    property p_value;
        (((pad_out_o ^ port_value_override_value_i) & pad_oe_o &
          port_value_override_enable_i) == '0) &&
        (((pad_out_o ^ latch_q) & pad_oe_o & ~pv_oe_eff) == '0);
    endproperty
    a_value: assert property (p_value)
        else $error("driven level wrong");

    property p_input_en;
        (((pad_input_en_o ^ {NPINS{~sleep}}) & ~ie_oe_eff) == '0);
    endproperty
    a_input_en: assert property (p_input_en)
        else $error("input enable does not follow sleep");

    property p_sync_delay;
        $past(nrst_i, 2) |-> pin_sync == $past(schmitt, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("input register not two cycles behind pad");

    property p_osc7;
        (as2 & ~external_clock_select) |-> !pad_oe_o[OSC_OUT_PIN] &&
            !pad_pullup_en_o[OSC_OUT_PIN] && !pad_input_en_o[OSC_OUT_PIN];
    endproperty
    a_osc7: assert property (p_osc7)
        else $error("bit 7 not released to timer oscillator");

    property p_osc6;
        (as2 | ~intrc) |-> !pad_oe_o[OSC_IN_PIN] &&
            !pad_pullup_en_o[OSC_IN_PIN] && !pad_input_en_o[OSC_IN_PIN];
    endproperty
    a_osc6: assert property (p_osc6)
        else $error("bit 6 not released to oscillator");

    property p_claim_reads;
        (avs_read_i && !avs_waitrequest_o &&
         $past(avs_address_i) < ADDR_CTRL) |->
            ((avs_readdata_o[NPINS-1:0] & clk_claim) == '0);
    endproperty
    a_claim_reads: assert property (p_claim_reads)
        else $error("claimed oscillator pin reads nonzero");

    property p_write_dir;
        (avs_write_i && avs_byteenable_i[0] &&
         avs_address_i == ADDR_DIR) |=> dir_q == $past(wdata);
    endproperty
    a_write_dir: assert property (p_write_dir)
        else $error("direction write not stored");

    property p_read_wait;
        (avs_read_i && !rd_pend_q) |-> avs_waitrequest_o ##1
            (!avs_waitrequest_o || !avs_read_i);
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read answer not after one wait cycle");

    c_tosc: cover property (tosc_active && !external_clock_select);
    c_override_drive: cover property (|(pad_oe_o & pv_oe_eff));
    c_read_claimed: cover property (avs_read_i && !avs_waitrequest_o
                                    && claim6);

endmodule // ppom_top

// file: ppom_pad_model.sv
`timescale 1ns/1ps
// far side of the pads: external drivers, pull-ups and a module-side synchroniser
module ppom_pad_model (
    input  wire logic       mclk_i,          // i/o clock
    input  wire logic [7:0] pad_out_i,       // level driven by the port
    input  wire logic [7:0] pad_oe_i,        // port driver enable
    input  wire logic [7:0] pad_pullup_en_i, // port pull-up enable
    input  wire logic [7:0] ext_en_i,        // an external driver is present
    input  wire logic [7:0] ext_val_i,       // external driven level
    input  wire logic [7:0] raw_i,           // unsynced input handed to the module
    output logic      [7:0] pad_o,           // resolved pad level
    output logic      [7:0] raw_sync_o       // module's own synchronised copy
);
    logic [7:0] float_q = 8'h5a; // undriven pads wander, so a stale level is never trusted
    logic [7:0] meta_q;          // first synchroniser stage
    // the module keeps its own two-stage synchroniser on the raw input
    always_ff @(posedge mclk_i) begin
        float_q    <= ~float_q;
        meta_q     <= raw_i;
        raw_sync_o <= meta_q;
    end
    // port driver wins, then an external driver, then the pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) pad_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
            else if (pad_pullup_en_i[i]) pad_o[i] = 1'b1;
            else pad_o[i] = float_q[i];
        end
    end
endmodule // ppom_pad_model

// file: tb_port_pin_override_mux.sv
`timescale 1ns/1ps
// self-checking bench: register bus tasks plus pad-level expectations
module tb_port_pin_override_mux;
    import ppom_pkg::*;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  adr = 8'h00, pu_oe = 8'h00, pu_ov = 8'h00, dd_oe = 8'h00, dd_ov = 8'h00;
    logic        rd = 1'b0, wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [3:0]  be = 4'hf;
    logic        wreq;
    logic [7:0]  pv_oe = 8'h00, pv_ov = 8'h00, ie_oe = 8'h00, ie_ov = 8'h00;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, pad_in, raw_sync;
    logic [7:0]  pad_out, pad_oe, pad_pu, pad_ie, alt_raw, ana, pcs;
    logic        chip_claim, timer_claim;
    logic [7:0]  dir_m = DIR_RESET, lat_m = LATCH_RESET, pce_m = PCEN_RESET, ctl_m = 8'h10;
    logic [31:0] dummy;
    int          failures = 0;
    int          n_tests = 0;
    always #4 mclk_i = ~mclk_i;
    ppom_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .pullup_override_enable_i(pu_oe), .pullup_override_value_i(pu_ov),
        .direction_override_enable_i(dd_oe), .direction_override_value_i(dd_ov),
        .port_value_override_enable_i(pv_oe), .port_value_override_value_i(pv_ov),
        .input_enable_override_enable_i(ie_oe), .input_enable_override_value_i(ie_ov),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .pad_pullup_en_o(pad_pu), .pad_input_en_o(pad_ie),
        .alt_function_raw_input_o(alt_raw), .analogue_pad_path_o(ana),
        .pin_change_source_o(pcs), .chip_osc_claim_o(chip_claim),
        .timer_osc_claim_o(timer_claim));
    ppom_pad_model i_pad (.mclk_i(mclk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .pad_pullup_en_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .raw_i(alt_raw), .pad_o(pad_in), .raw_sync_o(raw_sync));
    function automatic logic [31:0] z(input logic [7:0] v);
        return {24'h00_0000, v};
    endfunction
    // pins held by an oscillator, from the control bits
    function automatic logic [7:0] claims();
        logic rc;
        rc = ctl_m[CTRL_INTRC_BIT];
        return {(~rc & ~ctl_m[CTRL_EXTCK_BIT]) | (ctl_m[CTRL_AS2_BIT]
                & ~ctl_m[CTRL_EXTERNAL_CLOCK_SELECT_BIT]), ~rc | ctl_m[CTRL_AS2_BIT], 6'h00};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] b, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        logic ok;
        ok = 1'b0;
        @(posedge mclk_i);
        adr  <= a;
        wdat <= z(d);
        be   <= b;
        wr   <= w;
        rd   <= ~w;
        while (!ok) begin
            @(posedge mclk_i);
            ok = (wreq === 1'b0);
        end
        q  = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (w && b[0]) begin
            case (a)
                ADDR_DIR:   dir_m = d;
                ADDR_LATCH: lat_m = d;
                ADDR_INPUT: lat_m = lat_m ^ d;
                ADDR_CTRL:  ctl_m = d & 8'h3f;
                ADDR_PCEN:  pce_m = d;
                default: ;
            endcase
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 4'hf, a, d, dummy);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, 4'hf, a, 8'h00, q);
        chk($sformatf("register %h", a), z(exp), q);
    endtask
    task automatic set_ov(input logic [7:0] m, input logic [7:0] s);
        @(posedge mclk_i);
        pu_oe <= m & (8'h0f ^ s);
        pu_ov <= m & (8'h33 ^ s);
        dd_oe <= m & (8'h55 ^ s);
        dd_ov <= m & (8'hf0 ^ s);
        pv_oe <= m & (8'hcc ^ s);
        pv_ov <= m & (8'haa ^ s);
        ie_oe <= m & (8'h3c ^ s);
        ie_ov <= m & (8'h69 ^ s);
    endtask
    // expected pad controls from the register and override state
    task automatic chk_pads();
        logic [7:0] cl, pu, oe, ie;
        #1;
        cl = claims();
        pu = ((pu_oe & pu_ov) | (~pu_oe & ~dir_m & lat_m & ~{8{ctl_m[CTRL_PUD_BIT]}})) & ~cl;
        oe = ((dd_oe & dd_ov) | (~dd_oe & dir_m)) & ~cl;
        ie = ((ie_oe & ie_ov) | (~ie_oe & (pce_m | ~{8{ctl_m[CTRL_SLEEP_BIT]}}))) & ~cl;
        chk("pad_pullup_en_o", z(pu), z(pad_pu));
        chk("pad_oe_o", z(oe), z(pad_oe));
        chk("pad_out_o", z(((pv_oe & pv_ov) | (~pv_oe & lat_m)) & oe), z(pad_out));
        chk("pad_input_en_o", z(ie), z(pad_ie));
        chk("alt_function_raw_input_o", z(pad_in & ie), z(alt_raw));
        chk("analogue_pad_path_o", z(pad_in), z(ana));
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hung handshake cannot stall the run
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        chk_pads();
        rd_chk(ADDR_DIR, DIR_RESET);
        rd_chk(ADDR_LATCH, LATCH_RESET);
        rd_chk(ADDR_PCEN, PCEN_RESET);
        rd_chk(ADDR_CTRL, 8'(CTRL_RESET));
        rd_chk(8'h14, RDATA_NONE[7:0]);
        $display("test reset done");
        // every direction, latch and pull-up disable combination, no overrides
        for (int k = 0; k < 8; k++) begin
            wr_reg(ADDR_DIR, {8{k[2]}});
            wr_reg(ADDR_LATCH, {8{k[1]}});
            wr_reg(ADDR_CTRL, {7'h08, k[0]});
            chk_pads();
        end
        $display("test plain pins done");
        // overrides checked in the cycle they are applied, awake then asleep
        wr_reg(ADDR_DIR, 8'h33);
        wr_reg(ADDR_LATCH, 8'h56);
        for (int k = 0; k < 8; k++) begin
            if (k == 4) wr_reg(ADDR_CTRL, 8'h13);
            set_ov(8'hff, 8'(k * 17));
            chk_pads();
        end
        set_ov(8'h00, 8'h00);
        $display("test overrides done");
        // sampled inputs and pin change sources, asleep with some enables
        @(posedge mclk_i);
        ext_en  <= 8'hff;
        ext_val <= 8'h5a;
        wr_reg(ADDR_DIR, 8'h00);
        wr_reg(ADDR_LATCH, 8'h00);
        wr_reg(ADDR_PCEN, 8'hf0);
        wr_reg(ADDR_CTRL, 8'h12);
        repeat (3) @(posedge mclk_i);
        chk_pads();
        chk("raw_sync", z(8'h50), z(raw_sync));
        chk("pin_change_source_o", z(8'h50), z(pcs));
        rd_chk(ADDR_INPUT, 8'h50);
        wr_reg(ADDR_PCEN, 8'hff);
        wr_reg(ADDR_CTRL, 8'h10);
        repeat (3) @(posedge mclk_i);
        chk("pin_change_source_o", z(8'h5a), z(pcs));
        rd_chk(ADDR_INPUT, 8'h5a);
        wr_reg(ADDR_INPUT, 8'h81);
        rd_chk(ADDR_LATCH, 8'h81);
        $display("test inputs done");
        // every clock source and timer select combination
        wr_reg(ADDR_DIR, 8'hff);
        wr_reg(ADDR_LATCH, 8'hff);
        for (int c = 0; c < 16; c++) begin
            wr_reg(ADDR_CTRL, {2'b00, 4'(c), 2'b00});
            chk_pads();
            chk("chip_osc_claim_o", z({7'h00, ~ctl_m[CTRL_INTRC_BIT]}),
                z({7'h00, chip_claim}));
            chk("timer_osc_claim_o", z({7'h00, ctl_m[CTRL_INTRC_BIT] & ctl_m[CTRL_AS2_BIT]}),
                z({7'h00, timer_claim}));
            rd_chk(ADDR_DIR, ~claims());
            rd_chk(ADDR_LATCH, ~claims());
            rd_chk(ADDR_INPUT, ~claims());
        end
        $display("test oscillator pins done");
        // writes that must be ignored
        wr_reg(ADDR_CTRL, 8'h10);
        bus(1'b1, 4'he, ADDR_DIR, 8'h00, dummy);
        wr_reg(8'h14, 8'h00);
        rd_chk(ADDR_DIR, 8'hff);
        $display("test ignored writes done");
        summarize();
    end
endmodule // tb_port_pin_override_mux
